//--- hdl/ism_pkg.sv
// package: register map, codes, event carrier and timing of the indicator monitor
package ism_pkg;
  // instance and name sizing
  localparam int unsigned IND_COUNT  = 10;  // indicator instances
  localparam int unsigned NAME_CHARS = 32;  // longest indicator name
  localparam int unsigned NAME_WORDS = NAME_CHARS / 4;  // 32-bit words per name
  localparam int unsigned ADDR_W     = 9;   // byte address width

  // register byte offsets
  localparam logic [8:0] OFS_CTRL     = 9'h000;  // filter mode, setup flag
  localparam logic [8:0] OFS_STATE    = 9'h004;  // decoded indicator states
  localparam logic [8:0] OFS_IRQ_STAT = 9'h008;  // sticky change flags, clear on read
  localparam logic [8:0] OFS_IRQ_MASK = 9'h00C;  // interrupt mask
  localparam logic [8:0] OFS_TIME     = 9'h010;  // millisecond timestamp
  localparam logic [8:0] OFS_NAME     = 9'h040;  // name words, 8 per indicator

  // control field positions and reset values
  localparam int unsigned CTRL_MODE_LSB  = 0;
  localparam int unsigned CTRL_SETUP_BIT = 2;
  localparam logic [1:0]  CTRL_MODE_RST  = 2'h0;  // both on and off stored
  localparam logic        CTRL_SETUP_RST = 1'b1;  // start in setup phase

  // indicator status codes
  typedef enum logic [1:0] {
    IND_INTER  = 2'h0,
    IND_OPEN   = 2'h1,
    IND_CLOSED = 2'h2,
    IND_BAD    = 2'h3
  } ism_stat_e;

  // event buffer filter selection
  typedef enum logic [1:0] {
    FILT_BOTH = 2'h0,
    FILT_ON   = 2'h1,
    FILT_OFF  = 2'h2,
    FILT_RSV  = 2'h3
  } ism_filt_e;

  // one event toward the common event buffer
  typedef struct packed {
    logic        valid;  // one-cycle strobe
    logic [3:0]  src;    // instance number 1..10
    logic [1:0]  code;   // status the event concerns
    logic        on;     // 1 on, 0 off
    logic [31:0] stamp;  // milliseconds
  } ism_evt_s;

  // timestamp tick
  localparam int unsigned TS_RES_NS     = 1000000;  // 1 ms resolution
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned TS_CYCLES     = TS_RES_NS / CLK_PERIOD_NS;
endpackage

//--- hdl/ism_top.sv
// indicator status monitor: decode, event generation, register slave, interrupt
//
// Local design decisions: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps

module ism_top
#(
  parameter int unsigned N      = ism_pkg::IND_COUNT,  // indicator instances
  parameter int unsigned TS_DIV = ism_pkg::TS_CYCLES   // clocks per millisecond
)
(
  input  wire logic                          core_clk,
  input  wire logic                          reset,
  input  wire logic [N-1:0]                  open_pin,
  input  wire logic [N-1:0]                  close_pin,
  input  wire logic [ism_pkg::ADDR_W-1:0]    reg_addr,
  input  wire logic [31:0]                   reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output logic      [31:0]                   reg_rdata,
  output logic                               irq,
  output ism_pkg::ism_evt_s                  evt,
  output logic      [2*N-1:0]                ind_state
);

  localparam int unsigned DIVW  = $clog2(TS_DIV + 1);             // tick divider width
  localparam int unsigned NWRDS = N * ism_pkg::NAME_WORDS;        // name memory words
  localparam int unsigned NAME_END = ism_pkg::OFS_NAME + 4 * NWRDS; // first byte past names

  // whole module state, registered in one process
  typedef struct packed {
    logic [N-1:0]             s1_open;   // first sync stage
    logic [N-1:0]             s1_close;
    logic [N-1:0]             s2_open;   // second sync stage
    logic [N-1:0]             s2_close;
    logic [N-1:0][1:0]        rep;       // last reported status
    logic [N-1:0]             off_done;  // off event already sent
    logic [1:0]               mode;      // event filter
    logic                     setup;     // setup phase flag
    logic [N-1:0]             ist;       // sticky change flags
    logic [N-1:0]             imask;     // interrupt mask
    logic                     irq;
    logic [31:0]              ms;        // timestamp
    logic [DIVW-1:0]          div;       // tick divider
    logic [31:0]              rdata;
    ism_pkg::ism_evt_s        evt;
    logic [2*N-1:0]           state;     // decoded status out
    logic [NWRDS-1:0][31:0]   names;     // indicator names
  } ism_state_s;

  ism_state_s q_reg;   // current state
  ism_state_s q_next;  // next state

  // outputs straight from flops
  assign reg_rdata = q_reg.rdata;
  assign irq       = q_reg.irq;
  assign evt       = q_reg.evt;
  assign ind_state = q_reg.state;
  // no command output exists: the block only watches

  // next-state logic
  always_comb
  begin
    logic [N-1:0][1:0] cur;      // decoded synchronised status
    logic              found;    // an indicator is pending
    int unsigned       sel;      // lowest pending indicator
    logic              want_on;  // filter passes on events
    logic              want_off; // filter passes off events
    logic [8:0]        widx;     // name word index
    cur      = '0;
    found    = 1'b0;
    sel      = 0;
    want_on  = 1'b0;
    want_off = 1'b0;
    widx     = '0;
    q_next   = q_reg;

    // two-flop synchronisers; stage one feeds stage two only
    q_next.s1_open  = open_pin;
    q_next.s1_close = close_pin;
    q_next.s2_open  = q_reg.s1_open;
    q_next.s2_close = q_reg.s1_close;

    // decode: close in bit 1, open in bit 0 gives the status code directly
    for (int i = 0; i < N; i++)
    begin
      cur[i] = {q_reg.s2_close[i], q_reg.s2_open[i]};
    end
    q_next.state = cur;

    // millisecond timestamp
    if (q_reg.div == DIVW'(TS_DIV - 1))
    begin
      q_next.div = '0;
      q_next.ms  = q_reg.ms + 32'h1;
    end
    else
    begin
      q_next.div = q_reg.div + DIVW'(1);
    end

    // register bus; read data valid only the cycle after the read
    q_next.rdata = '0;
    if (reg_addr >= ism_pkg::OFS_NAME)
    begin
      widx = 9'((reg_addr - ism_pkg::OFS_NAME) >> 2);
    end
    if (reg_wr)
    begin
      case (reg_addr)
        ism_pkg::OFS_CTRL:
        begin
          // filter only moves while in setup; setup flag always writable
          if (q_reg.setup)
          begin
            q_next.mode = reg_wdata[ism_pkg::CTRL_MODE_LSB +: 2];
          end
          q_next.setup = reg_wdata[ism_pkg::CTRL_SETUP_BIT];
        end
        ism_pkg::OFS_IRQ_MASK:
        begin
          q_next.imask = reg_wdata[N-1:0];
        end
        default:
        begin
          // name words only writable in setup
          if (q_reg.setup && reg_addr >= ism_pkg::OFS_NAME && 32'(reg_addr) < NAME_END)
          begin
            q_next.names[widx] = reg_wdata;
          end
        end
      endcase
    end
    if (reg_rd)
    begin
      case (reg_addr)
        ism_pkg::OFS_CTRL:
        begin
          q_next.rdata = 32'({q_reg.setup, q_reg.mode});
        end
        ism_pkg::OFS_STATE:
        begin
          q_next.rdata = 32'(q_reg.state);
        end
        ism_pkg::OFS_IRQ_STAT:
        begin
          // read clears; a set below in this cycle still wins
          q_next.rdata = 32'(q_reg.ist);
          q_next.ist   = '0;
        end
        ism_pkg::OFS_IRQ_MASK:
        begin
          q_next.rdata = 32'(q_reg.imask);
        end
        ism_pkg::OFS_TIME:
        begin
          q_next.rdata = q_reg.ms;
        end
        default:
        begin
          // unmapped addresses read zero
          if (reg_addr >= ism_pkg::OFS_NAME && 32'(reg_addr) < NAME_END)
          begin
            q_next.rdata = q_reg.names[widx];
          end
        end
      endcase
    end

    // event arbiter: one event per cycle, lowest instance first;
    // no buffer, so a burst of changes is spread over several cycles
    // an instance whose off went out still owes its on, even if the status flicked back
    for (int i = 0; i < N; i++)
    begin
      if (!found && (cur[i] != q_reg.rep[i] || q_reg.off_done[i]))
      begin
        found = 1'b1;
        sel   = i;
      end
    end
    // the reserved filter code behaves as both
    want_on  = q_reg.mode != ism_pkg::FILT_OFF;
    want_off = q_reg.mode != ism_pkg::FILT_ON;
    q_next.evt       = '0;
    q_next.evt.src   = 4'(sel + 1);
    q_next.evt.stamp = q_reg.ms;
    if (found)
    begin
      if (!q_reg.off_done[sel] && want_off)
      begin
        // off for the old status first
        q_next.evt.valid = 1'b1;
        q_next.evt.code  = q_reg.rep[sel];
        q_next.evt.on    = 1'b0;
        q_next.off_done[sel] = 1'b1;
        if (!want_on)
        begin
          q_next.rep[sel]      = cur[sel];
          q_next.off_done[sel] = 1'b0;
          q_next.ist[sel]      = 1'b1;
        end
      end
      else
      begin
        // on for the newest status; a flicker after the off is folded
        q_next.evt.valid = want_on;
        q_next.evt.code  = cur[sel];
        q_next.evt.on    = 1'b1;
        q_next.rep[sel]      = cur[sel];
        q_next.off_done[sel] = 1'b0;
        q_next.ist[sel]      = 1'b1;
      end
    end

    // level interrupt from next sticky and mask
    q_next.irq = |(q_next.ist & q_next.imask);
  end

  // state register
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      // only setup leaves reset non-zero; mode loads its reset code, which is zero
      q_reg       <= '0;
      q_reg.mode  <= ism_pkg::CTRL_MODE_RST;
      q_reg.setup <= ism_pkg::CTRL_SETUP_RST;
    end
    else
    begin
      q_reg <= q_next;
    end
  end

  // decoded code follows synchronised inputs
  a_bad_code: assert property (@(posedge core_clk) disable iff (reset)
    (q_reg.s2_open[0] && q_reg.s2_close[0]) |=> ind_state[1:0] == 2'h3)
    else $error("both inputs active not shown as bad");
  a_inter_code: assert property (@(posedge core_clk) disable iff (reset)
    (!q_reg.s2_open[0] && !q_reg.s2_close[0]) |=> ind_state[1:0] == 2'h0)
    else $error("no input active not shown as intermediate");
  a_open_code: assert property (@(posedge core_clk) disable iff (reset)
    $rose(open_pin[0]) && !close_pin[0] ##1 !close_pin[0] ##1 !close_pin[0]
    |=> ind_state[1:0] == 2'h1)
    else $error("open input not shown as open after sync");
  a_closed_code: assert property (@(posedge core_clk) disable iff (reset)
    (q_reg.s2_close[0] && !q_reg.s2_open[0]) |=> ind_state[1:0] == 2'h2)
    else $error("close input not shown as closed");
  // event fields
  a_evt_src: assert property (@(posedge core_clk) disable iff (reset)
    evt.valid |-> (evt.src >= 4'h1 && 32'(evt.src) <= N))
    else $error("event source out of range");
  a_evt_stamp: assert property (@(posedge core_clk) disable iff (reset)
    evt.valid |-> evt.stamp == $past(q_reg.ms))
    else $error("event stamp not the current millisecond");
  a_filter_on: assert property (@(posedge core_clk) disable iff (reset)
    evt.valid && $past(q_reg.mode) == ism_pkg::FILT_ON |-> evt.on)
    else $error("off event passed on-only filter");
  a_filter_off: assert property (@(posedge core_clk) disable iff (reset)
    evt.valid && $past(q_reg.mode) == ism_pkg::FILT_OFF |-> !evt.on)
    else $error("on event passed off-only filter");
  a_setup_lock: assert property (@(posedge core_clk) disable iff (reset)
    !q_reg.setup |=> $stable(q_reg.mode))
    else $error("filter changed outside setup");
  a_irq_level: assert property (@(posedge core_clk) disable iff (reset)
    irq == |(q_reg.ist & q_reg.imask))
    else $error("interrupt does not follow unmasked flags");
  a_off_then_on: assert property (@(posedge core_clk) disable iff (reset)
    evt.valid && !evt.on && evt.src == 4'h1 && $past(q_reg.mode) == ism_pkg::FILT_BOTH
    |=> evt.valid && evt.on && evt.src == 4'h1)
    else $error("off event for instance one not followed by on");

  // read-back path: data of the addressed word, the cycle after the strobe only
  // idle bus reads zero
  a_rdata_idle: assert property (@(posedge core_clk) disable iff (reset)
    !$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data not zero outside a read");
  // sticky flags returned before the clear
  a_flags_read: assert property (@(posedge core_clk) disable iff (reset)
    $past(reg_rd && reg_addr == ism_pkg::OFS_IRQ_STAT) |-> reg_rdata == 32'($past(q_reg.ist)))
    else $error("flag read does not return sticky flags");
  // status word read
  a_state_read: assert property (@(posedge core_clk) disable iff (reset)
    $past(reg_rd && reg_addr == ism_pkg::OFS_STATE) |-> reg_rdata == 32'($past(q_reg.state)))
    else $error("state read does not return decoded states");
  // timestamp read
  a_time_read: assert property (@(posedge core_clk) disable iff (reset)
    $past(reg_rd && reg_addr == ism_pkg::OFS_TIME) |-> reg_rdata == $past(q_reg.ms))
    else $error("time read does not return millisecond count");
  // control read
  a_ctrl_read: assert property (@(posedge core_clk) disable iff (reset)
    $past(reg_rd && reg_addr == ism_pkg::OFS_CTRL) |-> reg_rdata == 32'($past({q_reg.setup, q_reg.mode})))
    else $error("control read does not return setup and filter");
  // mask read
  a_mask_read: assert property (@(posedge core_clk) disable iff (reset)
    $past(reg_rd && reg_addr == ism_pkg::OFS_IRQ_MASK) |-> reg_rdata == 32'($past(q_reg.imask)))
    else $error("mask read does not return mask");

  // event contents against the decoded status shown beside them
  // on event names the status now shown
  a_on_code: assert property (@(posedge core_clk) disable iff (reset)
    evt.valid && evt.on |-> evt.code == ind_state[2*(evt.src - 4'h1) +: 2])
    else $error("on event code differs from shown status");
  // off event names a status no longer shown
  a_off_code: assert property (@(posedge core_clk) disable iff (reset)
    evt.valid && !evt.on |-> evt.code != ind_state[2*(evt.src - 4'h1) +: 2])
    else $error("off event code equals shown status");
  // sticky flag only falls on a flag read
  a_sticky_hold: assert property (@(posedge core_clk) disable iff (reset)
    q_reg.ist[0] && !(reg_rd && reg_addr == ism_pkg::OFS_IRQ_STAT) |=> q_reg.ist[0])
    else $error("sticky flag lost without a read");

  // timestamp and settings storage
  // millisecond count only ever steps by one
  a_ms_step: assert property (@(posedge core_clk) disable iff (reset)
    $changed(q_reg.ms) |-> q_reg.ms == $past(q_reg.ms) + 32'h1)
    else $error("timestamp jumped");
  // divider never passes one millisecond
  a_div_range: assert property (@(posedge core_clk) disable iff (reset)
    32'(q_reg.div) < TS_DIV)
    else $error("tick divider out of range");
  // names frozen while running
  a_name_lock: assert property (@(posedge core_clk) disable iff (reset)
    !q_reg.setup |=> $stable(q_reg.names))
    else $error("name changed outside setup");
  // name write lands in setup
  a_name_write: assert property (@(posedge core_clk) disable iff (reset)
    reg_wr && q_reg.setup && reg_addr == ism_pkg::OFS_NAME |=> q_reg.names[0] == $past(reg_wdata))
    else $error("name word not stored in setup");

endmodule

//--- bench/ism_contact_model.sv
// model of the switchgear auxiliary contacts feeding the status pins
`timescale 1ns/1ps

module ism_contact_model
#(
  parameter int unsigned N = 10  // indicator count
)
(
  core_clk,
  pos_code,
  single_in,
  open_pin,
  close_pin
);
  input  wire logic            core_clk;   // system clock
  input  wire logic [2*N-1:0]  pos_code;   // wanted contact pair, {close,open}
  input  wire logic [N-1:0]    single_in;  // one contact plus its inverted copy
  output logic      [N-1:0]    open_pin;   // open contact per indicator
  output logic      [N-1:0]    close_pin;  // closed contact per indicator

  // contacts move just after the edge, like a real auxiliary switch with no bounce
  always_ff @(posedge core_clk)
  begin
    for (int i = 0; i < N; i++)
    begin
      open_pin[i]  <= pos_code[2*i];
      // single wiring cannot show bad or intermediate, a known limitation
      close_pin[i] <= single_in[i] ? !pos_code[2*i] : pos_code[2*i+1];
    end
  end
endmodule

//--- bench/testbench.sv
// self-checking bench of the indicator status monitor
`timescale 1ns/1ps

module testbench;
  localparam int unsigned N = ism_pkg::IND_COUNT;  // indicator count
  logic                        core_clk  = 1'b0;   // 100 MHz clock
  logic                        reset     = 1'b1;   // held for 8 cycles
  logic [ism_pkg::ADDR_W-1:0]  reg_addr  = '0;     // bus address
  logic [31:0]                 reg_wdata = '0;     // bus write data
  logic                        reg_wr    = 1'b0;   // write strobe
  logic                        reg_rd    = 1'b0;   // read strobe
  logic [31:0]                 reg_rdata;          // read data
  logic                        irq;                // interrupt level
  ism_pkg::ism_evt_s           evt;                // event toward buffer
  logic [2*N-1:0]              ind_state;          // decoded states
  logic [N-1:0]                open_pin;           // from contact model
  logic [N-1:0]                close_pin;          // from contact model
  logic [2*N-1:0]              pos_code  = '0;     // wanted contact states
  logic [N-1:0]                single_in = '0;     // single-input wiring
  logic [31:0]                 d;                  // read result
  logic [N-1:0]                mask;               // interrupt mask in use
  int                          miscompares = 0;    // mismatch count
  int                          checked = 0;        // comparison count
  int                          cyc = 0;            // cycles since release
  ism_pkg::ism_evt_s           evq[$];             // captured events
  int                          tq[$];              // cycle of each event

  // clock
  always #5 core_clk = ~core_clk;

  ism_top #(.N(N), .TS_DIV(10)) i_dut (.core_clk(core_clk), .reset(reset), .open_pin(open_pin),
    .close_pin(close_pin), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(irq), .evt(evt), .ind_state(ind_state));
  ism_contact_model #(.N(N)) i_contacts (.core_clk(core_clk), .pos_code(pos_code), .single_in(single_in),
    .open_pin(open_pin), .close_pin(close_pin));

  // event capture; sampled before the edge updates land, so no race
  always @(posedge core_clk)
  begin
    cyc <= reset ? 0 : cyc + 1;
    if (evt.valid === 1'b1)
    begin
      evq.push_back(evt);
      tq.push_back(cyc);
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // one-cycle write, entered just after an edge
  task automatic reg_write(input logic [8:0] a, input logic [31:0] v);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    // one edge passes so a following write never reassigns the strobe in this step
    @(posedge core_clk);
  endtask

  // read data stand only in the cycle after the strobe
  task automatic reg_read(input logic [8:0] a, output logic [31:0] v);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
    @(posedge core_clk);
  endtask

  // events expected from one change under a filter mode
  function automatic int exp_count(input logic [1:0] o, input logic [1:0] n, input logic [1:0] m);
    if (o == n)
      return 0;
    return (m == ism_pkg::FILT_ON || m == ism_pkg::FILT_OFF) ? 1 : 2;
  endfunction

  // move one indicator and judge state, events, stamps and interrupt
  task automatic move(input int k, input logic [1:0] nc, input logic [1:0] m);
    logic [1:0] old;
    int         n;
    int         dt;
    old = pos_code[2*k +: 2];
    n   = exp_count(old, nc, m);
    evq.delete();
    tq.delete();
    pos_code[2*k +: 2] <= nc;
    repeat (12) @(posedge core_clk);
    check(ind_state[2*k +: 2], nc, "state");
    check(evq.size(), n, "event count");
    foreach (evq[j])
    begin
      dt = tq[j] / 10 - int'(evq[j].stamp);
      check(evq[j].src, k + 1, "source");
      check(evq[j].on, (n == 2) ? j : (m == ism_pkg::FILT_ON), "on flag");
      check(evq[j].code, evq[j].on ? nc : old, "code");
      check(dt >= -1 && dt <= 2, 1, "stamp");
    end
    check(irq, mask[k] && n > 0, "irq raised");
    reg_read(ism_pkg::OFS_IRQ_STAT, d);
    check(d, (n > 0) ? (32'h1 << k) : 32'h0, "flags");
    repeat (2) @(posedge core_clk);
    check(irq, 1'b0, "irq cleared");
  endtask

  // watchdog
  initial
  begin
    repeat (6000) @(posedge core_clk);
    miscompares++;
    finish_test();
  end

  // main sequence
  initial
  begin
    void'($urandom(32'h72D2));
    repeat (8) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    reg_read(ism_pkg::OFS_CTRL, d);
    check(d, 32'h4, "ctrl reset");
    reg_read(ism_pkg::OFS_STATE, d);
    check(d, 32'h0, "state reset");
    reg_read(9'h020, d);
    check(d, 32'h0, "unmapped");
    // name storage in setup, then frozen once running
    reg_write(ism_pkg::OFS_NAME + 9'h124, 32'h496E6439);
    reg_read(ism_pkg::OFS_NAME + 9'h124, d);
    check(d, 32'h496E6439, "name");
    reg_write(ism_pkg::OFS_CTRL, 32'h0);
    reg_write(ism_pkg::OFS_NAME + 9'h124, 32'h0);
    reg_read(ism_pkg::OFS_NAME + 9'h124, d);
    check(d, 32'h496E6439, "name frozen");
    mask = 10'($urandom);
    reg_write(ism_pkg::OFS_IRQ_MASK, {22'h0, mask});
    reg_read(ism_pkg::OFS_IRQ_MASK, d);
    check(d, {22'h0, mask}, "mask readback");
    // counter runs one tick per ten cycles in this bench
    reg_read(ism_pkg::OFS_TIME, d);
    check(32'(int'(d) >= cyc / 10 - 2 && int'(d) <= cyc / 10 + 1), 32'h1, "time");
    for (int m = 0; m < 4; m++)
    begin
      reg_write(ism_pkg::OFS_CTRL, 32'h4);
      reg_write(ism_pkg::OFS_CTRL, 32'h4 | m);
      reg_write(ism_pkg::OFS_CTRL, m);
      reg_write(ism_pkg::OFS_CTRL, 32'h3 & ~m);
      reg_read(ism_pkg::OFS_CTRL, d);
      check(d, m, "mode kept while running");
      repeat (10) move($urandom_range(N - 1), 2'($urandom), 2'(m));
      for (int c = 0; c < 4; c++)
        move(N - 1, 2'(c), 2'(m));
      reg_read(ism_pkg::OFS_STATE, d);
      check(d, 32'(pos_code), "state word");
    end
    // one contact with its inverted copy
    move(0, ism_pkg::IND_OPEN, 2'h3);
    single_in <= 10'h001;
    repeat (3) move(0, ism_pkg::IND_CLOSED, 2'h3) ;
    move(0, ism_pkg::IND_OPEN, 2'h3);
    finish_test();
  end
endmodule
